// *** adc_port_pkg.sv ***
// Constants shared by the converter parallel output port.
package adc_port_pkg;
  localparam int WORD_WIDTH = 12;
  localparam int SAMPLE_BIT_MSB = 11;
  localparam int SAMPLE_BIT_LSB = 0;
  localparam int PIPE_DEPTH = 3;
  localparam logic [11:0] WORD_RESET = 12'h000;
  localparam logic OE_N_RESET = 1'h0;
  localparam logic INVERT_RESET = 1'h0;
  localparam int CLK_PERIOD_NS = 100;
  localparam int MIN_CONV_PERIOD_NS = 1000;
  localparam int MIN_CONV_PERIOD_CYC = (MIN_CONV_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// *** adc_parallel_port.sv ***
// Parallel sample port of a pipelined converter: latency pipe, format and three-state output.
//
// Function
// (RULE1) New word every conversion clock, from the sample taken 2.5 cycles earlier.
// (RULE2) Drive the twelve lines only while the active-low enable is asserted.
// (RULE3) Invert select high flips the top bit, giving two's complement output.
// (RULE4) Strobe output is a delayed copy of the conversion clock.
// (RULE5) Twelve-bit word, line 11 carries the MSB, line 0 the LSB.
// (RULE6) Host keeps the conversion clock at one million samples per second or less.
// (RULE7) Floating enable and invert inputs read low: port on, straight binary.
// (RULE8) Pipeline keeps running while disabled; re-enable shows current result at once.
`timescale 1ns/1ns
module adc_parallel_port
  import adc_port_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic conv_clk_i,
  input wire logic [WORD_WIDTH-1:0] conv_data_i,
  input wire logic output_enable_n_i,
  input wire logic msb_invert_select_i,
  output logic [WORD_WIDTH-1:0] sample_word_o,
  output logic sample_word_oe_o,
  output logic sample_strobe_o
);

  // Conversion clock takes three stages: two to synchronise it, a third to see its edges.
  logic clk_s1_q, clk_s1_d;
  logic clk_s2_q, clk_s2_d;
  logic clk_s3_q, clk_s3_d;
  logic oe_n_s1_q, oe_n_s1_d;
  logic oe_n_s2_q, oe_n_s2_d;
  logic inv_s1_q, inv_s1_d;
  logic inv_s2_q, inv_s2_d;
  // Sample pipeline, release register and output stage.
  logic [WORD_WIDTH-1:0] pipe_q [PIPE_DEPTH];
  logic [WORD_WIDTH-1:0] pipe_d [PIPE_DEPTH];
  logic [WORD_WIDTH-1:0] raw_q, raw_d;
  logic [WORD_WIDTH-1:0] word_q, word_d;
  logic oe_q, oe_d;
  logic conv_rise;
  logic conv_fall;

  // Edges are taken from the second and third stages so the first stage stays a pure synchroniser.
  assign conv_rise = clk_s2_q & ~clk_s3_q;
  assign conv_fall = ~clk_s2_q & clk_s3_q;

  // Walk of one sample, counted in system clock edges after the pin rises:
  // edge 2 sees the rise in the second stage, edge 3 loads stage 0 of the pipe.
  // Two further rises move the sample to the last stage, and the fall that follows
  // copies it to the release register; the output register shows it one edge later.
  // A conversion half period shorter than one system cycle can be missed entirely,
  // which is why the host must keep the conversion clock at or below its rated rate.
  // The enable and invert pins do not touch this path, so toggling them never
  // costs a sample.

  // Next values for synchronisers, pipeline and output stage.
  always_comb begin
    clk_s1_d = conv_clk_i;
    clk_s2_d = clk_s1_q;
    clk_s3_d = clk_s2_q; // [RULE4]
    oe_n_s1_d = output_enable_n_i;
    oe_n_s2_d = oe_n_s1_q;
    inv_s1_d = msb_invert_select_i;
    inv_s2_d = inv_s1_q;
    // The pipe advances on rising edges only and ignores the enable. [RULE8]
    for (int i = 0; i < PIPE_DEPTH; i++) begin
      pipe_d[i] = pipe_q[i];
    end
    if (conv_rise) begin
      pipe_d[0] = conv_data_i; // [RULE1]
      for (int i = 1; i < PIPE_DEPTH; i++) begin
        pipe_d[i] = pipe_q[i-1];
      end
    end
    // The word is released half a cycle after the third rising edge, i.e. 2.5 cycles. [RULE1]
    raw_d = conv_fall ? pipe_q[PIPE_DEPTH-1] : raw_q;
    // Until three rises have passed after reset, a fall releases the all-zero reset word.
    // Format is applied every cycle so a change of select shows without waiting for a sample.
    word_d = raw_q; // [RULE5]
    word_d[SAMPLE_BIT_MSB] = raw_q[SAMPLE_BIT_MSB] ^ inv_s2_q; // [RULE3]
    oe_d = ~oe_n_s2_q; // [RULE2]
  end

  // Registers; reset values leave the port enabled and in straight binary. [RULE7]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_s1_q <= 1'h0;
      clk_s2_q <= 1'h0;
      clk_s3_q <= 1'h0;
      oe_n_s1_q <= OE_N_RESET;
      oe_n_s2_q <= OE_N_RESET;
      inv_s1_q <= INVERT_RESET;
      inv_s2_q <= INVERT_RESET;
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pipe_q[i] <= WORD_RESET;
      end
      raw_q <= WORD_RESET;
      word_q <= WORD_RESET;
      oe_q <= ~OE_N_RESET;
    end else begin
      clk_s1_q <= clk_s1_d;
      clk_s2_q <= clk_s2_d;
      clk_s3_q <= clk_s3_d;
      oe_n_s1_q <= oe_n_s1_d;
      oe_n_s2_q <= oe_n_s2_d;
      inv_s1_q <= inv_s1_d;
      inv_s2_q <= inv_s2_d;
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pipe_q[i] <= pipe_d[i];
      end
      raw_q <= raw_d;
      word_q <= word_d;
      oe_q <= oe_d;
    end
  end

  // Data stays registered while disabled; the enable alone decides whether lines are driven.
  assign sample_word_o = word_q;
  assign sample_word_oe_o = oe_q;
  assign sample_strobe_o = clk_s3_q;

  // Checks on the pipeline, format and three-state control.
  AST_SAMPLE_CAPTURE: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
    conv_rise |=> pipe_q[0] == $past(conv_data_i))
    else $error("Sample not captured on conversion clock rise.");

  AST_LATENCY_RELEASE: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
    conv_fall |=> raw_q == $past(pipe_q[2]))
    else $error("Released word is not the sample from 2.5 cycles back.");

  AST_HOLD_BETWEEN: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
    !conv_fall |=> $stable(raw_q))
    else $error("Output word changed away from a falling conversion edge.");

  AST_MSB_FORMAT: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
    ##1 sample_word_o[11] == ($past(raw_q[11]) ^ $past(inv_s2_q)))
    else $error("Top bit does not follow the invert select.");

  AST_LOW_BITS: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
    ##1 sample_word_o[10:0] == $past(raw_q[10:0]))
    else $error("Lower bits are not passed straight to lines 10 to 0.");

  AST_TRISTATE: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
    oe_n_s2_q |=> !sample_word_oe_o)
    else $error("Lines driven while the enable is deasserted.");

  AST_DRIVE: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
    !output_enable_n_i ##1 !output_enable_n_i ##1 !output_enable_n_i |=> sample_word_oe_o)
    else $error("Lines not driven three cycles after enable asserted.");

  AST_STROBE: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
    ##3 sample_strobe_o == $past(conv_clk_i, 3))
    else $error("Strobe is not the conversion clock delayed by three cycles.");

  AST_RUN_WHILE_OFF: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
    (conv_rise && oe_n_s2_q) |=> pipe_q[1] == $past(pipe_q[0]))
    else $error("Pipeline stalled while the port is disabled.");

  AST_RESET_STATE: assert property (@(posedge clk_i) // [RULE7]
    rst_i |=> sample_word_oe_o && !inv_s2_q)
    else $error("Reset does not leave the port enabled in straight binary.");

  // Three-state control must follow the synchronised enable in both directions.
  AST_OE_RELEASE: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
    output_enable_n_i ##1 output_enable_n_i ##1 output_enable_n_i |=> !sample_word_oe_o)
    else $error("Lines still driven three cycles after enable deasserted.");

  AST_OE_STEADY: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
    $stable(oe_n_s2_q) |=> $stable(sample_word_oe_o))
    else $error("Drive control changed without a change of the enable.");

  // The strobe edges line up with the edges that load and release samples.
  AST_STROBE_RISE: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
    conv_rise |=> $rose(sample_strobe_o))
    else $error("Strobe did not rise with the sampling edge.");

  AST_STROBE_FALL: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
    conv_fall |=> $fell(sample_strobe_o))
    else $error("Strobe did not fall with the release edge.");

  AST_STROBE_STEADY: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
    (!conv_rise && !conv_fall) |=> $stable(sample_strobe_o))
    else $error("Strobe moved without a conversion clock edge.");

  // Lines 10 to 0 move only two edges after a release, one word per period.
  AST_WORD_STEADY: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
    ($changed(sample_word_o[SAMPLE_BIT_MSB-1:SAMPLE_BIT_LSB])
      && !$past(rst_i) && !$past(rst_i, 2)) |-> $past(conv_fall, 2))
    else $error("Data lines changed away from a release.");

  AST_REENABLE_CURRENT: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
    ($rose(sample_word_oe_o) && !$past(rst_i)) |-> sample_word_o[SAMPLE_BIT_MSB-1:SAMPLE_BIT_LSB]
      == $past(raw_q[SAMPLE_BIT_MSB-1:SAMPLE_BIT_LSB]))
    else $error("Re-enabled port does not show the current result.");

  // Every stage holds between rises, so a slow conversion clock cannot smear two samples.
  for (genvar g = 0; g < PIPE_DEPTH; g++) begin : pipe_hold
    AST_PIPE_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
      !conv_rise |=> $stable(pipe_q[g]))
      else $error("Pipeline stage changed without a conversion clock rise.");
  end

  // On each rise every later stage takes the one before it, whatever the enable.
  for (genvar g = 1; g < PIPE_DEPTH; g++) begin : pipe_shift
    AST_PIPE_SHIFT: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
      conv_rise |=> pipe_q[g] == $past(pipe_q[g-1]))
      else $error("Pipeline stage did not take the stage before it on a rise.");
  end

  // Covers for the main traffic cases.
  COV_RELEASE: cover property (@(posedge clk_i) disable iff (rst_i)
    conv_fall ##1 sample_word_oe_o);
  COV_INVERTED: cover property (@(posedge clk_i) disable iff (rst_i)
    inv_s2_q && conv_fall);
  COV_REENABLE: cover property (@(posedge clk_i) disable iff (rst_i)
    !sample_word_oe_o ##1 sample_word_oe_o);
  COV_RUN_DISABLED: cover property (@(posedge clk_i) disable iff (rst_i)
    conv_rise && !sample_word_oe_o);
  COV_STRAIGHT: cover property (@(posedge clk_i) disable iff (rst_i)
    !inv_s2_q && conv_fall);

endmodule

// *** host_capture_model.sv ***
// Host model: makes the conversion clock and a known pattern on the quantiser input.
`timescale 1ns/1ns
module host_capture_model (
  input wire logic clk_i,
  input wire logic run_i,
  output logic conv_clk_o,
  output logic [11:0] conv_data_o,
  output logic [11:0] period_count_o
);
  logic [3:0] phase_q;
  logic run_q;
  initial begin
    phase_q = 4'h0;
    run_q = 1'b0;
    conv_clk_o = 1'b0;
    conv_data_o = 12'h000;
    period_count_o = 12'h000;
  end
  // Ten system cycles per period holds the rate at the one-million-sample ceiling.
  // Data changes only at the rise, so it is steady well past the sampling point.
  // Run is taken on the rising edge, since the bench changes it on the falling one.
  always @(posedge clk_i) begin
    run_q <= run_i;
  end
  always @(negedge clk_i) begin
    if (run_q) begin
      phase_q <= (phase_q == 4'h9) ? 4'h0 : phase_q + 4'h1;
      conv_clk_o <= (phase_q < 4'h5);
      if (phase_q == 4'h0) begin
        period_count_o <= period_count_o + 12'h1;
        conv_data_o <= 12'ha5c ^ ((period_count_o + 12'h1) * 12'h123);
      end
    end
  end
endmodule

// *** adc_parallel_port_bench.sv ***
// Self-checking bench for the converter parallel output port.
`timescale 1ns/1ns
module adc_parallel_port_bench;
  import adc_port_pkg::*;
  logic clk, rst, oe_n, inv, conv_clk, strobe, oe;
  logic [WORD_WIDTH-1:0] conv_data, word, n;
  // The three-state lines are resolved here, so a disabled port must read as all Z.
  wire [WORD_WIDTH-1:0] lines = oe ? word : 12'hzzz;
  int miscompares = 0;
  int total_checks = 0;
  host_capture_model host (.clk_i(clk), .run_i(!rst), .conv_clk_o(conv_clk),
    .conv_data_o(conv_data), .period_count_o(n));
  adc_parallel_port uut (.clk_i(clk), .rst_i(rst), .conv_clk_i(conv_clk),
    .conv_data_i(conv_data), .output_enable_n_i(oe_n), .msb_invert_select_i(inv),
    .sample_word_o(word), .sample_word_oe_o(oe), .sample_strobe_o(strobe));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [11:0] pattern(input logic [11:0] k);
    return 12'ha5c ^ (k * 12'h123);
  endfunction
  task automatic cmp(input logic [11:0] got, input logic [11:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask
  // One conversion period: strobe timing, then the word of the sample three rises back.
  task automatic observe(input logic i, input logic e);
    logic [11:0] k;
    @(posedge conv_clk);
    @(negedge clk);
    // The count moves on the same edge as the rise, so it is read one edge later.
    k = n;
    cmp({11'h0, strobe}, 12'h0, "strobe early");
    repeat (3) @(negedge clk);
    cmp({11'h0, strobe}, 12'h1, "strobe late");
    cmp(lines, e ? pattern(k - 12'h3) ^ {i, 11'h0} : 12'hzzz, "word");
  endtask
  task automatic test_latency;
    repeat (4) observe(1'b0, 1'b1);
    $display("latency test done");
  endtask
  task automatic test_invert;
    inv = 1'b1;
    repeat (2) observe(1'b1, 1'b1);
    inv = 1'b0;
    observe(1'b0, 1'b1);
    $display("invert test done");
  endtask
  // Re-enabling must show the running pipeline at once, not a stale word.
  task automatic test_disable;
    oe_n = 1'b1;
    repeat (3) observe(1'b0, 1'b0);
    oe_n = 1'b0;
    observe(1'b0, 1'b1);
    $display("disable test done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Idle-low enable and invert stand for the floating pins.
  initial begin
    rst = 1'b1;
    oe_n = 1'b0;
    inv = 1'b0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    cmp({11'h0, oe}, 12'h1, "enabled at rest");
    repeat (3) @(posedge conv_clk);
    test_latency();
    test_invert();
    test_disable();
    test_done();
  end
  // Watchdog: the run needs about 150 cycles.
  initial begin
    repeat (2000) @(posedge clk);
    miscompares++;
    test_done();
  end
endmodule
